/* rtl/distance_pd_pkg.sv */
// Constants, field layout and state codes of the distance process data port.
// Assumes a single 10 MHz system clock shared by every module that imports it.
package distance_pd_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ          = 10_000_000;
    localparam int READY_TIME_MS   = 2000;
    localparam int READY_CYCLES    = READY_TIME_MS * (CLK_HZ / 1000);
    localparam int POLL_MIN_US     = 4000;
    localparam int POLL_MIN_CYCLES = POLL_MIN_US * (CLK_HZ / 1_000_000);
    localparam int COM2_BAUD       = 38400;
    localparam int BOOT_WAIT       = 2;
    // ****************************************************************
    // Process data word layout
    // ****************************************************************
    localparam int PD_W       = 32;
    localparam int DIST_LSB   = 0;
    localparam int DIST_W     = 27;
    localparam int SPARE_LSB  = 27;
    localparam int SPARE_W    = 2;
    localparam int SW3_BIT    = 29;
    localparam int SW2_BIT    = 30;
    localparam int SW1_BIT    = 31;
    localparam int FIFO_DEPTH = 32;
    localparam int REFL_W     = 2;
    localparam int CNT_W      = 26;
    localparam int POLL_W     = 17;
    // ****************************************************************
    // Run states
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_BOOT = 3'b001,
        ST_IDLE = 3'b010,
        ST_MEAS = 3'b100
    } run_state_e;
endpackage

/* rtl/distance_pd_port.sv */
// Device-side process data port of a laser distance sensor.
// Assumes the measuring core, the link layer and the setting store share clk_sys;
// only the saved autostart level comes from outside and is synchronised.
// Summary of operation
// - Laser starts at power-up only when an active state was saved.
// - Ready is reported about two seconds after power is applied.
// - A saved running measurement resumes at power-up without any command.
// - Process data is one 32-bit word, device to master only.
// - The word holds a 27-bit integer and three boolean fields.
// - Bits 0 to 26 carry signed distance in tenths of a millimetre.
// - Switch state 3 in bit 29, 2 in bit 30, 1 in bit 31.
// - Reflection indicator is driven per measurement and lights on measurement start.
// - Parameter, identification and diagnosis traffic never interrupts process data.
// - Master can back up and restore the device parameters.
module distance_pd_port
    import distance_pd_pkg::*;
#(
    parameter int READY_CNT = READY_CYCLES,
    parameter int POLL_CNT  = POLL_MIN_CYCLES,
    parameter int DEPTH     = FIFO_DEPTH
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic              nvAutostart,
    input  wire logic              activeMeasurementCommand,
    input  wire logic              stopCommand,
    input  wire logic              paramSave,
    input  wire logic              measValid,
    output logic                   measReady,
    input  wire logic [DIST_W-1:0] measDist,
    input  wire logic              limitSwitchState1,
    input  wire logic              limitSwitchState2,
    input  wire logic              limitSwitchState3,
    input  wire logic [REFL_W-1:0] reflStrength,
    output logic                   pdValid,
    input  wire logic              pdReady,
    output logic      [PD_W-1:0]   pdData,
    input  wire logic              dsBackupReq,
    output logic                   dsBackupValid,
    output logic                   dsBackupAutostart,
    input  wire logic              dsRestoreValid,
    input  wire logic              dsRestoreAutostart,
    output logic                   nvSaveStrobe,
    output logic                   laserOn,
    output logic                   deviceReady,
    output logic                   signalLedOn,
    output logic      [REFL_W-1:0] signalLevel,
    output logic                   pollTooFast
);
    initial begin
        if (READY_CNT < 2 || READY_CNT >= (1 << CNT_W)) begin
            $error("distance_pd_port: READY_CNT out of range");
        end
        if (POLL_CNT < 2 || POLL_CNT >= (1 << POLL_W)) begin
            $error("distance_pd_port: POLL_CNT out of range");
        end
    end

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        run_state_e        state;
        logic [1:0]        bootCnt;
        logic [CNT_W-1:0]  readyCnt;
        logic              ready;
        logic              savedAuto;
        logic              signalOn;
        logic [REFL_W-1:0] level;
        logic [POLL_W-1:0] pollCnt;
        logic              popSeen;
        logic              pollErr;
        logic              bkValid;
        logic              nvSave;
    } port_s;

    port_s             st_r;
    port_s             st_nxt;
    logic              autoSync;
    logic [PD_W-1:0]   pdWord;
    logic              pushValid;
    logic              pushReady;
    logic              pop;

    sync_2ff #(
        .WIDTH (1)
    ) u_auto_sync (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .asyncIn (nvAutostart),
        .syncOut (autoSync)
    );

    // ****************************************************************
    // Word packing
    // ****************************************************************
    always_comb begin
        pdWord                           = '0;
        pdWord[DIST_LSB +: DIST_W]       = measDist;
        pdWord[SPARE_LSB +: SPARE_W]     = '0;
        pdWord[SW3_BIT]                  = limitSwitchState3;
        pdWord[SW2_BIT]                  = limitSwitchState2;
        pdWord[SW1_BIT]                  = limitSwitchState1;
    end

    // Samples are taken only while the laser runs; a full queue stalls the core.
    assign pushValid = measValid && (st_r.state == ST_MEAS);
    assign measReady = pushReady && (st_r.state == ST_MEAS);
    assign pop       = pdValid && pdReady;

    pd_fifo #(
        .WIDTH (PD_W),
        .DEPTH (DEPTH)
    ) u_pd_fifo (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (pdWord),
        .outValid (pdValid),
        .outReady (pdReady),
        .outData  (pdData)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_nxt         = st_r;
        st_nxt.bkValid = 1'b0;
        st_nxt.nvSave  = 1'b0;
        // Readiness runs from power-up regardless of what the laser does.
        if (!st_r.ready) begin
            if (st_r.readyCnt == CNT_W'(READY_CNT - 1)) begin
                st_nxt.ready = 1'b1;
            end else begin
                st_nxt.readyCnt = st_r.readyCnt + 1'b1;
            end
        end
        case (st_r.state)
            // The synchroniser needs two edges to fill after reset, hence the short boot wait.
            ST_BOOT: begin
                if (st_r.bootCnt == 2'(BOOT_WAIT)) begin
                    st_nxt.savedAuto = autoSync;
                    if (autoSync) begin
                        st_nxt.state    = ST_MEAS;
                        st_nxt.signalOn = 1'b1;
                    end else begin
                        st_nxt.state = ST_IDLE;
                    end
                end else begin
                    st_nxt.bootCnt = st_r.bootCnt + 1'b1;
                end
            end
            ST_IDLE: begin
                if (activeMeasurementCommand) begin
                    st_nxt.state    = ST_MEAS;
                    st_nxt.signalOn = 1'b1;
                end
            end
            ST_MEAS: begin
                if (stopCommand) begin
                    st_nxt.state    = ST_IDLE;
                    st_nxt.signalOn = 1'b0;
                end
            end
            default: begin
                st_nxt.state = ST_IDLE;
            end
        endcase
        // The indicator follows the sample actually queued, so a stalled core cannot skew it.
        if (pushValid && pushReady) begin
            st_nxt.level = reflStrength;
        end
        // Acyclic services touch only the setting store, never the queue.
        if (st_r.state != ST_BOOT) begin
            if (dsRestoreValid) begin
                st_nxt.savedAuto = dsRestoreAutostart;
                st_nxt.nvSave    = 1'b1;
            end else if (paramSave) begin
                st_nxt.savedAuto = (st_r.state == ST_MEAS);
                st_nxt.nvSave    = 1'b1;
            end
            st_nxt.bkValid = dsBackupReq;
        end
        // Poll spacing monitor; the counter saturates so long gaps stay legal.
        if (pop) begin
            if (st_r.popSeen && st_r.pollCnt < POLL_W'(POLL_CNT)) begin
                st_nxt.pollErr = 1'b1;
            end
            st_nxt.popSeen = 1'b1;
            st_nxt.pollCnt = POLL_W'(1);
        end else if (st_r.pollCnt != '1) begin
            st_nxt.pollCnt = st_r.pollCnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r       <= '0;
            st_r.state <= ST_BOOT;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign laserOn           = st_r.state == ST_MEAS;
    assign deviceReady       = st_r.ready;
    assign signalLedOn       = st_r.signalOn;
    assign signalLevel       = st_r.level;
    assign dsBackupValid     = st_r.bkValid;
    assign dsBackupAutostart = st_r.savedAuto;
    assign nvSaveStrobe      = st_r.nvSave;
    assign pollTooFast       = st_r.pollErr;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    AST_AUTOSTART: assert property (
        (st_r.state == ST_BOOT && st_r.bootCnt == 2'(BOOT_WAIT)) |=> (laserOn == $past(autoSync)))
        else $error("laser start at boot does not follow saved state");
    AST_READY_TIME: assert property (
        $rose(deviceReady) |-> $past(st_r.readyCnt) == CNT_W'(READY_CNT - 1))
        else $error("ready raised at wrong count");
    AST_READY_HOLD: assert property (
        deviceReady |=> deviceReady)
        else $error("ready dropped");
    AST_RESUME: assert property (
        (st_r.state == ST_BOOT && st_r.bootCnt == 2'(BOOT_WAIT) && autoSync) |=> laserOn && signalLedOn)
        else $error("saved measurement not resumed");
    AST_NO_PUSH_IDLE: assert property (
        !laserOn |-> !measReady)
        else $error("sample taken while laser off");
    AST_PACK: assert property (
        (measValid && measReady && !pdValid) |=> pdData[DIST_LSB +: DIST_W] == $past(measDist)
            && pdData[SW1_BIT] == $past(limitSwitchState1) && pdData[SW2_BIT] == $past(limitSwitchState2)
            && pdData[SW3_BIT] == $past(limitSwitchState3))
        else $error("process word packing wrong");
    AST_SPARE: assert property (
        pdValid |-> pdData[SPARE_LSB +: SPARE_W] == '0)
        else $error("spare bits not zero");
    AST_LED_START: assert property (
        $rose(laserOn) |-> signalLedOn)
        else $error("indicator not lit at start");
    AST_RESTORE: assert property (
        (dsRestoreValid && st_r.state != ST_BOOT) |=> nvSaveStrobe && dsBackupAutostart == $past(dsRestoreAutostart))
        else $error("restore not stored");
    AST_BACKUP: assert property (
        (dsBackupReq && st_r.state != ST_BOOT) |=> dsBackupValid ##1 !dsBackupValid || $past(dsBackupReq))
        else $error("backup answer wrong");
    AST_POLL: assert property (
        (pop && st_r.popSeen && st_r.pollCnt < POLL_W'(POLL_CNT)) |=> pollTooFast)
        else $error("fast poll not flagged");
    AST_POLL_STICKY: assert property (
        pollTooFast |=> pollTooFast)
        else $error("fast poll flag cleared");

    AST_READY_EARLY: assert property (
        (!deviceReady && st_r.readyCnt != CNT_W'(READY_CNT - 1)) |=> !deviceReady)
        else $error("ready raised early");
    AST_BOOT_DARK: assert property (
        (st_r.state == ST_BOOT) |-> !laserOn && !signalLedOn)
        else $error("laser lit during boot");
    AST_IDLE_START: assert property (
        (st_r.state == ST_IDLE && activeMeasurementCommand) |=> laserOn && signalLedOn)
        else $error("start command not honoured");
    AST_STOP: assert property (
        (laserOn && stopCommand) |=> !laserOn && !signalLedOn)
        else $error("stop command not honoured");
    AST_LEVEL: assert property (
        (measValid && measReady) |=> signalLevel == $past(reflStrength))
        else $error("indicator level not taken from queued sample");

    // Acyclic traffic shares no path with the queue, so a waiting head word must never move.
    AST_PD_HOLD: assert property (
        (pdValid && !pdReady) |=> pdValid && $stable(pdData))
        else $error("waiting process word disturbed");
    AST_SAMPLE_TAKEN: assert property (
        (measValid && measReady) |=> pdValid)
        else $error("accepted sample not offered to the master");
    AST_PARAM_SAVE: assert property (
        (paramSave && !dsRestoreValid && st_r.state != ST_BOOT)
            |=> nvSaveStrobe && dsBackupAutostart == $past(laserOn))
        else $error("running state not saved");
    AST_BOOT_QUIET: assert property (
        (st_r.state == ST_BOOT) |=> !nvSaveStrobe && !dsBackupValid)
        else $error("storage service answered during boot");

    // ****************************************************************
    // Coverage
    // ****************************************************************
    COV_AUTOSTART: cover property ($rose(laserOn) && $past(st_r.state) == ST_BOOT);
    COV_FULL: cover property (laserOn && measValid && !pushReady);
    COV_RESTORE: cover property (dsRestoreValid ##1 nvSaveStrobe);
    COV_FAST_POLL: cover property (pop && st_r.popSeen && st_r.pollCnt < POLL_W'(POLL_CNT));
    COV_BACKUP: cover property (dsBackupReq ##1 dsBackupValid);
endmodule // distance_pd_port

/* rtl/pd_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth must be a power of two.
module pd_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin
            $error("pd_fifo: DEPTH must be a power of two of at least 2");
        end
    end

    typedef struct packed {
        logic [AW:0] wrPtr;
        logic [AW:0] rdPtr;
    } fifo_s;

    fifo_s            st_r;
    fifo_s            st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign inReady  = (st_r.wrPtr - st_r.rdPtr) != (AW+1)'(DEPTH);
    assign outValid = st_r.wrPtr != st_r.rdPtr;
    assign outData  = mem[st_r.rdPtr[AW-1:0]];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wrPtr = st_r.wrPtr + 1'b1;
        end
        if (pop) begin
            st_nxt.rdPtr = st_r.rdPtr + 1'b1;
        end
    end

    // The storage has no reset; only the pointers define what is valid.
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[st_r.wrPtr[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // pd_fifo

/* rtl/sync_2ff.sv */
// Two-flop synchroniser for levels arriving from outside the clock domain.
// Assumes the input is a slow level; pulses shorter than one cycle may be lost.
module sync_2ff #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;

    always_comb begin
        st_nxt.meta   = asyncIn;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign syncOut = st_r.stable;
endmodule // sync_2ff

/* tb/link_master_model.sv */
// Behavioural IO-Link master that pops process data words at a set poll spacing.
// Assumes it shares clk_sys with the port and that the bench reads its queue.
module link_master_model #(
    parameter int GAP = 8
) (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        pdValid,
    input  wire logic [31:0] pdData,
    input  wire logic        holdOff,
    input  wire logic        fast,
    output logic             pdReady
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] got[$];
    int          gap;
    initial pdReady = 1'b0;
    // The master only collects words; it sends no output process data.
    // Ready moves on the rising edge so the bench's falling-edge controls never race it.
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gap = GAP;
            pdReady <= 1'b0;
        end else begin
            if (pdValid && pdReady) begin
                got.push_back(pdData);
                gap = 0;
            end else begin
                gap = gap + 1;
            end
            // A well behaved master waits out the minimum cycle time; fast mode breaks that on purpose.
            pdReady <= !holdOff && (fast || gap >= GAP);
        end
    end
endmodule // link_master_model

/* tb/tb.sv */
// Self-checking bench of the distance process data port with a master model.
// Assumes short READY_CNT and POLL_CNT so the run stays brief.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import distance_pd_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic nvAutostart = 1'b0, activeMeasurementCommand = 1'b0, stopCommand = 1'b0;
    logic paramSave = 1'b0, measValid = 1'b0, measReady, pdValid, pdReady;
    logic [DIST_W-1:0] measDist = '0;
    logic limitSwitchState1 = 1'b0, limitSwitchState2 = 1'b0, limitSwitchState3 = 1'b0;
    logic [REFL_W-1:0] reflStrength = '0, signalLevel;
    logic [PD_W-1:0] pdData;
    logic dsBackupReq = 1'b0, dsBackupValid, dsBackupAutostart, dsRestoreValid = 1'b0;
    logic dsRestoreAutostart = 1'b0, nvSaveStrobe, laserOn, deviceReady, signalLedOn, pollTooFast;
    logic holdOff = 1'b1, fast = 1'b0;
    logic [31:0] expQ[$];
    int err_total = 0, checks_done = 0;

    always #50 clk_sys = ~clk_sys;

    distance_pd_port #(.READY_CNT(20), .POLL_CNT(8), .DEPTH(32)) distance_pd_port_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .nvAutostart(nvAutostart),
        .activeMeasurementCommand(activeMeasurementCommand), .stopCommand(stopCommand),
        .paramSave(paramSave), .measValid(measValid), .measReady(measReady), .measDist(measDist),
        .limitSwitchState1(limitSwitchState1), .limitSwitchState2(limitSwitchState2),
        .limitSwitchState3(limitSwitchState3), .reflStrength(reflStrength), .pdValid(pdValid),
        .pdReady(pdReady), .pdData(pdData), .dsBackupReq(dsBackupReq), .dsBackupValid(dsBackupValid),
        .dsBackupAutostart(dsBackupAutostart), .dsRestoreValid(dsRestoreValid),
        .dsRestoreAutostart(dsRestoreAutostart), .nvSaveStrobe(nvSaveStrobe), .laserOn(laserOn),
        .deviceReady(deviceReady), .signalLedOn(signalLedOn), .signalLevel(signalLevel),
        .pollTooFast(pollTooFast)
    );

    link_master_model #(.GAP(8)) link_master_model_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .pdValid(pdValid), .pdData(pdData),
        .holdOff(holdOff), .fast(fast), .pdReady(pdReady)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic results();
        $display("errors=%0d checks=%0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic doReset(input logic auto);
        @(negedge clk_sys);
        rst_n = 1'b0;
        nvAutostart = auto;
        repeat (6) @(negedge clk_sys);
        link_master_model_i.got.delete();
        rst_n = 1'b1;
    endtask

    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(negedge clk_sys);
        sig = 1'b0;
    endtask

    // Offers one sample and returns right after the edge that takes it.
    task automatic pushSample(input int i);
        logic [26:0] d;
        int k;
        d = 27'(i + 1) * 27'h00ABCDE;
        if (i[0]) d = ~d;
        if (i == 2) d = 27'h3FFFFFF;
        @(negedge clk_sys);
        measValid = 1'b1;
        measDist = d;
        {limitSwitchState1, limitSwitchState2, limitSwitchState3} = 3'(i);
        reflStrength = 2'(i >> 3);
        expQ.push_back({3'(i), 2'b00, d});
        for (k = 0; k < 200 && measReady !== 1'b1; k++) @(negedge clk_sys);
        if (measReady !== 1'b1) begin
            chk(32'h0, 32'h1);
            results();
        end
        @(posedge clk_sys);
    endtask

    task automatic waitGot(input int n);
        int k;
        for (k = 0; k < 5000 && link_master_model_i.got.size() < n; k++) @(negedge clk_sys);
        if (link_master_model_i.got.size() < n) begin
            chk(32'(link_master_model_i.got.size()), 32'(n));
            results();
        end
    endtask

    task automatic compareAll();
        foreach (expQ[j]) chk(link_master_model_i.got[j], expQ[j]);
        expQ.delete();
        link_master_model_i.got.delete();
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic bootNoAutostart();
        repeat (8) @(negedge clk_sys);
        chk(32'(laserOn), 32'h0);
        chk(32'(deviceReady), 32'h0);
        repeat (11) @(negedge clk_sys);
        chk(32'(deviceReady), 32'h0);
        @(negedge clk_sys);
        chk(32'(deviceReady), 32'h1);
        repeat (2) @(negedge clk_sys);
    endtask

    task automatic startStop();
        pulse(activeMeasurementCommand);
        chk(32'(laserOn), 32'h1);
        chk(32'(signalLedOn), 32'h1);
        pulse(stopCommand);
        chk(32'(signalLedOn), 32'h0);
        chk(32'(measReady), 32'h0);
        pulse(activeMeasurementCommand);
    endtask

    // Parameter traffic runs while the master keeps draining process data.
    task automatic storageMidDrain();
        pulse(paramSave);
        chk(32'(nvSaveStrobe), 32'h1);
        chk(32'(dsBackupAutostart), 32'h1);
        dsRestoreAutostart = 1'b0;
        pulse(dsRestoreValid);
        chk(32'(nvSaveStrobe), 32'h1);
        chk(32'(dsBackupAutostart), 32'h0);
        pulse(dsBackupReq);
        chk(32'(dsBackupValid), 32'h1);
        chk(32'(nvSaveStrobe), 32'h0);
        @(negedge clk_sys);
        chk(32'(dsBackupValid), 32'h0);
    endtask

    task automatic fillAndDrain();
        for (int i = 0; i < 32; i++) pushSample(i);
        @(negedge clk_sys);
        measValid = 1'b0;
        chk(32'(measReady), 32'h0);
        chk(pdData, expQ[0]);
        chk(32'(signalLevel), 32'h3);
        holdOff = 1'b0;
        waitGot(4);
        storageMidDrain();
        waitGot(32);
        compareAll();
        chk(32'(pdValid), 32'h0);
        chk(32'(pollTooFast), 32'h0);
    endtask

    task automatic fastPolling();
        fast = 1'b1;
        pushSample(5);
        pushSample(6);
        @(negedge clk_sys);
        measValid = 1'b0;
        waitGot(2);
        compareAll();
        repeat (2) @(negedge clk_sys);
        chk(32'(pollTooFast), 32'h1);
    endtask

    task automatic bootAutostart();
        repeat (2) @(negedge clk_sys);
        chk(32'(laserOn), 32'h0);
        repeat (4) @(negedge clk_sys);
        chk(32'(laserOn), 32'h1);
        chk(32'(signalLedOn), 32'h1);
        chk(32'(deviceReady), 32'h0);
    endtask

    initial begin
        doReset(1'b0);
        bootNoAutostart();
        startStop();
        fillAndDrain();
        fastPolling();
        fast = 1'b0;
        doReset(1'b1);
        bootAutostart();
        results();
    end
endmodule // tb
